/* pif_top.sv */
// Peripheral interrupt flag bank: flags, enables, global control, request
// Function
// - A flag sets on its peripheral condition regardless of any enable bit.
// - Each flag is one bit: one pending, zero not pending.
// - First flag register holds eight peripheral flags in the given order.
// - Serial port 1 receive and transmit flags are read-only, follow sources.
// - All implemented flags clear to zero on every reset.
// - Second flag register: six flags high, capture 2 at bit 0, bit 1 zero.
// - Third flag register: captures 5-3, timer6, timer4; bits 7,2,0 zero.
// - Fourth flag register: serial2 rx/tx, port2 collision/flag; rest zero.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module pif_top
  import pif_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input pif_addr_t reg_addr,
  input pif_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pif_byte_t reg_rdata,
  input pif_byte_t pir_cond1,
  input pif_byte_t pir_cond2,
  input pif_byte_t pir_cond3,
  input pif_byte_t pir_cond4,
  input pif_byte_t core_cond,
  output logic core_irq_req,
  output pif_byte_t timer0_and_pin_options,
  output logic evt_irq
);
  pif_bus_s bus;
  pif_byte_t cond [NUM_PIR];
  pif_byte_t pir [NUM_PIR];
  pif_byte_t pir_new [NUM_PIR];
  pif_byte_t pie [NUM_PIR];
  pif_wr_s pir_wr [NUM_PIR];
  pif_wr_s interrupt_global_control_wr;
  pif_byte_t interrupt_global_control_flags;
  pif_byte_t interrupt_global_control_ctl;
  pif_byte_t interrupt_global_control;
  pif_byte_t next_rdata;
  pif_evt_t evt;
  pif_evt_t evt_status;
  pif_evt_t evt_mask;
  logic evt_irq_q;
  logic periph_hit;
  logic own_hit;
  logic pending;

  always_comb begin
    bus.wr = reg_wr;
    bus.rd = reg_rd;
    bus.addr = reg_addr;
    bus.wdata = reg_wdata;
  end

  assign cond[0] = pir_cond1;
  assign cond[1] = pir_cond2;
  assign cond[2] = pir_cond3;
  assign cond[3] = pir_cond4;

  // Request flag registers; layouts come from the mask tables
  for (genvar g = 0; g < NUM_PIR; g++) begin : g_pir
    always_comb begin
      pir_wr[g].en = pif_hit(bus, A_PIR[g]);
      pir_wr[g].data = bus.wdata;
    end

    pif_flag_reg #(
      .IMPL(PIR_IMPL[g]),
      .RO(PIR_RO[g])
    ) u_flags (
      .mclk(mclk),
      .srst(srst),
      .wr(pir_wr[g]),
      .cond(cond[g]),
      .flags(pir[g]),
      .new_set(pir_new[g])
    );

    // Enables reset clear, so no stale request after reset
    always_ff @(posedge mclk) begin
      if (srst) begin
        pie[g] <= RST_ENABLE;
      end else if (pif_hit(bus, A_PIE[g])) begin
        pie[g] <= bus.wdata & PIE_IMPL[g];
      end
    end
  end

  // Global control: enables are plain storage, low bits are flags
  always_comb begin
    interrupt_global_control_wr.en = pif_hit(bus, A_INTERRUPT_GLOBAL_CONTROL);
    interrupt_global_control_wr.data = bus.wdata;
  end

  pif_flag_reg #(
    .IMPL(INTERRUPT_GLOBAL_CONTROL_FLAGS),
    .RO(RST_FLAGS)
  ) u_core_flags (
    .mclk(mclk),
    .srst(srst),
    .wr(interrupt_global_control_wr),
    .cond(core_cond),
    .flags(interrupt_global_control_flags),
    .new_set()
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      interrupt_global_control_ctl <= RST_INTERRUPT_GLOBAL_CONTROL;
    end else if (interrupt_global_control_wr.en) begin
      interrupt_global_control_ctl <= bus.wdata & ~INTERRUPT_GLOBAL_CONTROL_FLAGS;
    end
  end

  assign interrupt_global_control = interrupt_global_control_ctl | interrupt_global_control_flags;

  always_ff @(posedge mclk) begin
    if (srst) begin
      timer0_and_pin_options <= RST_OPTION;
    end else if (pif_hit(bus, A_OPTION)) begin
      timer0_and_pin_options <= bus.wdata;
    end
  end

  // Core request; peripheral group also needs its own enable
  always_comb begin
    periph_hit = 1'b0;
    for (int i = 0; i < NUM_PIR; i++) begin
      periph_hit = periph_hit | (|(pir[i] & pie[i]));
    end
    own_hit = |((interrupt_global_control >> INTERRUPT_GLOBAL_CONTROL_EN_SHIFT) & interrupt_global_control & INTERRUPT_GLOBAL_CONTROL_FLAGS);
    pending = interrupt_global_control[B_GIE]
      & ((periph_hit & interrupt_global_control[B_PERIPHERAL_INTERRUPT_ENABLE]) | own_hit);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      core_irq_req <= 1'b0;
    end else begin
      core_irq_req <= pending;
    end
  end

  // Events: a flag newly set per register, and a fresh core request
  always_comb begin
    for (int i = 0; i < NUM_PIR; i++) begin
      evt[i] = |pir_new[i];
    end
    evt[EVT_CORE] = pending & ~core_irq_req;
  end

  pif_evt_unit u_evt (
    .mclk(mclk),
    .srst(srst),
    .evt(evt),
    .stat_wr(pif_hit(bus, A_EVT_STAT)),
    .mask_wr(pif_hit(bus, A_EVT_MASK)),
    .wdata(bus.wdata[EVT_W-1:0]),
    .status(evt_status),
    .mask(evt_mask),
    .irq(evt_irq_q)
  );

  assign evt_irq = evt_irq_q;

  // Read path; data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = RD_NONE;
    if (bus.rd) begin
      unique case (bus.addr)
        A_INTERRUPT_GLOBAL_CONTROL: next_rdata = interrupt_global_control;
        A_OPTION: next_rdata = timer0_and_pin_options;
        A_PIR[0]: next_rdata = pir[0];
        A_PIR[1]: next_rdata = pir[1];
        A_PIR[2]: next_rdata = pir[2];
        A_PIR[3]: next_rdata = pir[3];
        A_PIE[0]: next_rdata = pie[0];
        A_PIE[1]: next_rdata = pie[1];
        A_PIE[2]: next_rdata = pie[2];
        A_PIE[3]: next_rdata = pie[3];
        A_EVT_STAT: next_rdata = {3'h0, evt_status};
        A_EVT_MASK: next_rdata = {3'h0, evt_mask};
        default: next_rdata = RD_NONE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= RD_NONE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  sequence s_read(pif_addr_t a);
    reg_rd && (reg_addr == a);
  endsequence

  property p_rd_peripheral_request_flags_1;
    @(posedge mclk) disable iff (srst)
    s_read(A_PIR[0]) |=> reg_rdata == $past(pir[0]);
  endproperty
  a_rd_peripheral_request_flags_1: assert property (p_rd_peripheral_request_flags_1)
    else $error("first flag register read mismatch");

  property p_rd_peripheral_request_flags_2_gap;
    @(posedge mclk) disable iff (srst)
    s_read(A_PIR[1]) |=> !reg_rdata[1];
  endproperty
  a_rd_peripheral_request_flags_2_gap: assert property (p_rd_peripheral_request_flags_2_gap)
    else $error("second flag register bit 1 not zero");

  property p_rd_peripheral_request_flags_3_gap;
    @(posedge mclk) disable iff (srst)
    s_read(A_PIR[2]) |=> (reg_rdata & 8'h85) == RD_NONE;
  endproperty
  a_rd_peripheral_request_flags_3_gap: assert property (p_rd_peripheral_request_flags_3_gap)
    else $error("third flag register reserved bits not zero");

  property p_rd_peripheral_request_flags_4_gap;
    @(posedge mclk) disable iff (srst)
    s_read(A_PIR[3]) |=> (reg_rdata & 8'hCC) == RD_NONE;
  endproperty
  a_rd_peripheral_request_flags_4_gap: assert property (p_rd_peripheral_request_flags_4_gap)
    else $error("fourth flag register reserved bits not zero");

  property p_rd_idle;
    @(posedge mclk) disable iff (srst)
    !reg_rd |=> reg_rdata == RD_NONE;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data present without a read");

  sequence s_cond_no_enable;
    pir_cond1[0] && !pie[0][0] && !interrupt_global_control[B_GIE];
  endsequence

  property p_flag_indep;
    @(posedge mclk) disable iff (srst)
    s_cond_no_enable |=> pir[0][0] ##1 (pir[0][0] || $past(pir_wr[0].en));
  endproperty
  a_flag_indep: assert property (p_flag_indep)
    else $error("flag did not set without enables");

  property p_ro_write;
    @(posedge mclk) disable iff (srst)
    pir_wr[0].en && !pir_cond1[B_SER1_RX] && !pir_cond1[B_SER1_TX]
      |=> !pir[0][B_SER1_RX] && !pir[0][B_SER1_TX];
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("software write changed a read-only flag");

  property p_reset_clear;
    @(posedge mclk) disable iff (srst)
    $fell(srst) |-> pir[0] == RST_FLAGS && pir[1] == RST_FLAGS
      && pir[2] == RST_FLAGS && pir[3] == RST_FLAGS;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags not clear after reset");

  property p_core_req;
    @(posedge mclk) disable iff (srst)
    1 |=> core_irq_req == $past(pending);
  endproperty
  a_core_req: assert property (p_core_req)
    else $error("core request does not track pending state");

  sequence s_global_off;
    !interrupt_global_control[B_GIE] [*2];
  endsequence

  property p_gie_blocks;
    @(posedge mclk) disable iff (srst)
    s_global_off |-> !core_irq_req;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks)
    else $error("core request while global enable off");

  property p_periph_gate;
    @(posedge mclk) disable iff (srst)
    interrupt_global_control[B_GIE] && interrupt_global_control[B_PERIPHERAL_INTERRUPT_ENABLE] && (|(pir[1] & pie[1]))
      |=> core_irq_req;
  endproperty
  a_periph_gate: assert property (p_periph_gate)
    else $error("enabled peripheral flag gave no core request");

  property p_rd_peripheral_enable_1;
    @(posedge mclk) disable iff (srst)
    s_read(A_PIE[0]) |=> reg_rdata == $past(pie[0]);
  endproperty
  a_rd_peripheral_enable_1: assert property (p_rd_peripheral_enable_1)
    else $error("first enable register read mismatch");

  property p_rd_peripheral_enable_3_gap;
    @(posedge mclk) disable iff (srst)
    s_read(A_PIE[2]) |=> (reg_rdata & 8'h85) == RD_NONE;
  endproperty
  a_rd_peripheral_enable_3_gap: assert property (p_rd_peripheral_enable_3_gap)
    else $error("third enable register reserved bits not zero");

  property p_rd_interrupt_global_control;
    @(posedge mclk) disable iff (srst)
    s_read(A_INTERRUPT_GLOBAL_CONTROL) |=> reg_rdata == $past(interrupt_global_control);
  endproperty
  a_rd_interrupt_global_control: assert property (p_rd_interrupt_global_control)
    else $error("global control read mismatch");

  property p_rd_option;
    @(posedge mclk) disable iff (srst)
    s_read(A_OPTION) |=> reg_rdata == $past(timer0_and_pin_options);
  endproperty
  a_rd_option: assert property (p_rd_option)
    else $error("option register read mismatch");

  property p_rd_evt;
    @(posedge mclk) disable iff (srst)
    s_read(A_EVT_STAT) |=> reg_rdata[EVT_W-1:0] == $past(evt_status);
  endproperty
  a_rd_evt: assert property (p_rd_evt)
    else $error("event status read mismatch");

  property p_peripheral_interrupt_enable_blocks;
    @(posedge mclk) disable iff (srst)
    !interrupt_global_control[B_PERIPHERAL_INTERRUPT_ENABLE] && !own_hit |=> !core_irq_req;
  endproperty
  a_peripheral_interrupt_enable_blocks: assert property (p_peripheral_interrupt_enable_blocks)
    else $error("core request with peripheral enable off");

  property p_own_req;
    @(posedge mclk) disable iff (srst)
    interrupt_global_control[B_GIE] && own_hit |=> core_irq_req;
  endproperty
  a_own_req: assert property (p_own_req)
    else $error("enabled core-group flag gave no core request");

  property p_flag_indep4;
    @(posedge mclk) disable iff (srst)
    pir_cond4[0] && !pie[3][0] |=> pir[3][0];
  endproperty
  a_flag_indep4: assert property (p_flag_indep4)
    else $error("fourth register flag did not set without enable");

  property p_reset_ctl;
    @(posedge mclk) disable iff (srst)
    $fell(srst) |-> interrupt_global_control == RST_INTERRUPT_GLOBAL_CONTROL && reg_rdata == RD_NONE
      && !core_irq_req && !evt_irq;
  endproperty
  a_reset_ctl: assert property (p_reset_ctl)
    else $error("control state not clear after reset");
endmodule

/* pif_pkg.sv */
// Shared constants and types for the peripheral interrupt flag bank
package pif_pkg;
  typedef logic [3:0] pif_addr_t;
  typedef logic [7:0] pif_byte_t;
  localparam int unsigned NUM_PIR = 4;
  localparam int unsigned EVT_W = 5;
  typedef logic [EVT_W-1:0] pif_evt_t;

  localparam pif_addr_t A_INTERRUPT_GLOBAL_CONTROL = 4'h0;
  localparam pif_addr_t A_OPTION = 4'h1;
  localparam pif_addr_t A_PIR [NUM_PIR] = '{4'h2, 4'h3, 4'h4, 4'h5};
  localparam pif_addr_t A_PIE [NUM_PIR] = '{4'h6, 4'h7, 4'h8, 4'h9};
  localparam pif_addr_t A_EVT_STAT = 4'hA;
  localparam pif_addr_t A_EVT_MASK = 4'hB;

  // Implemented and read-only bits per request register
  localparam pif_byte_t PIR_IMPL [NUM_PIR] = '{8'hFF, 8'hFD, 8'h7A, 8'h33};
  localparam pif_byte_t PIR_RO [NUM_PIR] = '{8'h30, 8'h00, 8'h00, 8'h00};
  localparam pif_byte_t PIE_IMPL [NUM_PIR] = '{8'hFF, 8'hFF, 8'h7A, 8'h33};

  localparam pif_byte_t RST_FLAGS = 8'h00;
  localparam pif_byte_t RST_ENABLE = 8'h00;
  localparam pif_byte_t RST_INTERRUPT_GLOBAL_CONTROL = 8'h00;
  localparam pif_byte_t RST_OPTION = 8'h00;
  localparam pif_byte_t RD_NONE = 8'h00;
  localparam pif_evt_t RST_EVT = 5'h00;

  // Global control layout
  localparam int unsigned B_GIE = 7;
  localparam int unsigned B_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam pif_byte_t INTERRUPT_GLOBAL_CONTROL_FLAGS = 8'h07;
  localparam int unsigned INTERRUPT_GLOBAL_CONTROL_EN_SHIFT = 3;

  localparam int unsigned B_SER1_RX = 5;
  localparam int unsigned B_SER1_TX = 4;
  localparam int unsigned EVT_CORE = 4;

  typedef struct packed {
    logic en;
    pif_byte_t data;
  } pif_wr_s;

  typedef struct packed {
    logic wr;
    logic rd;
    pif_addr_t addr;
    pif_byte_t wdata;
  } pif_bus_s;

  function automatic logic pif_hit(pif_bus_s b, pif_addr_t a);
    return b.wr && (b.addr == a);
  endfunction
endpackage

/* pif_flag_reg.sv */
// One 8-bit request flag register with hardware set and software write
`timescale 1ns/10ps
module pif_flag_reg
  import pif_pkg::*;
#(
  parameter pif_byte_t IMPL = 8'hFF,
  parameter pif_byte_t RO = 8'h00
) (
  input wire logic mclk,
  input wire logic srst,
  input pif_wr_s wr,
  input pif_byte_t cond,
  output pif_byte_t flags,
  output pif_byte_t new_set
);
  pif_byte_t next_flags;

  always_comb begin
    next_flags = wr.en ? wr.data : flags;
    next_flags = next_flags | cond;
    next_flags = (next_flags & ~RO) | (cond & RO);
    next_flags = next_flags & IMPL;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flags <= RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  assign new_set = cond & ~flags & IMPL;

  property p_set_wins;
    @(posedge mclk) disable iff (srst)
    1 |=> ((flags & IMPL & ~RO) & $past(cond)) == ($past(cond) & IMPL & ~RO);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("hardware set lost against write");

  property p_ro_follow;
    @(posedge mclk) disable iff (srst)
    1 |=> (flags & RO) == ($past(cond) & RO & IMPL);
  endproperty
  a_ro_follow: assert property (p_ro_follow)
    else $error("read-only flag does not follow its source");

  property p_unimpl_zero;
    @(posedge mclk) disable iff (srst)
    (flags & ~IMPL) == RST_FLAGS;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented flag bit set");
endmodule

/* pif_evt_unit.sv */
// Sticky event status with mask and level interrupt output
`timescale 1ns/10ps
module pif_evt_unit
  import pif_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input pif_evt_t evt,
  input wire logic stat_wr,
  input wire logic mask_wr,
  input pif_evt_t wdata,
  output pif_evt_t status,
  output pif_evt_t mask,
  output logic irq
);
  pif_evt_t next_status;
  pif_evt_t next_mask;

  always_comb begin
    // Set wins over a write-one clear in the same cycle
    next_status = (status & ~(stat_wr ? wdata : RST_EVT)) | evt;
    next_mask = mask_wr ? wdata : mask;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      status <= RST_EVT;
      mask <= RST_EVT;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end

  property p_irq_level;
    @(posedge mclk) disable iff (srst)
    irq == |(status & mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("event interrupt does not match status and mask");
endmodule

/* pif_periph_model.sv */
// Event source model for the peripherals and core in front of the flags
`timescale 1ns/10ps
module pif_periph_model
  import pif_pkg::*;
(
  input wire logic fire,
  input wire logic [2:0] sel,
  input pif_byte_t bits,
  input wire logic [1:0] ser_lvl,
  output pif_byte_t pir_cond1,
  output pif_byte_t pir_cond2,
  output pif_byte_t pir_cond3,
  output pif_byte_t pir_cond4,
  output pif_byte_t core_cond
);
  logic [4:0] hit;

  // Sources pulse with no regard to any enable bit
  assign hit = fire ? (5'h01 << sel) : 5'h00;
  // Serial 1 sources are levels, never pulses
  assign pir_cond1 = (hit[0] ? bits & 8'hCF : 8'h00) | {2'h0, ser_lvl, 4'h0};
  assign pir_cond2 = hit[1] ? bits : 8'h00;
  assign pir_cond3 = hit[2] ? bits : 8'h00;
  assign pir_cond4 = hit[3] ? bits : 8'h00;
  assign core_cond = hit[4] ? bits : 8'h00;
endmodule

/* peripheral_interrupt_flags_tb.sv */
// Self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/10ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module peripheral_interrupt_flags_tb
  import pif_pkg::*;
;
  typedef struct packed {
    logic wr;
    pif_addr_t a;
    pif_byte_t d;
    pif_byte_t e;
  } pif_row_s;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  pif_addr_t reg_addr = 4'h0;
  pif_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fire = 1'b0;
  logic [2:0] sel = 3'h0;
  pif_byte_t bits = 8'h00;
  logic [1:0] ser_lvl = 2'h0;
  pif_byte_t reg_rdata, c1, c2, c3, c4, cc, opt;
  logic core_irq_req, evt_irq;
  int miscompares = 0;
  int tests_run = 0;
  pif_row_s rows [16] = '{
    '{1'b0, 4'h2, 8'h00, 8'hCF},
    '{1'b0, 4'h3, 8'h00, 8'hFD},
    '{1'b0, 4'h4, 8'h00, 8'h7A},
    '{1'b0, 4'h5, 8'h00, 8'h33},
    '{1'b0, 4'hA, 8'h00, 8'h0F},
    '{1'b1, 4'h2, 8'hFF, 8'h00},
    '{1'b0, 4'h2, 8'h00, 8'hCF},
    '{1'b1, 4'h2, 8'h00, 8'h00},
    '{1'b0, 4'h2, 8'h00, 8'h00},
    '{1'b1, 4'h1, 8'h5A, 8'h00},
    '{1'b0, 4'h1, 8'h00, 8'h5A},
    '{1'b1, 4'hC, 8'hFF, 8'h00},
    '{1'b0, 4'hC, 8'h00, 8'h00},
    '{1'b1, 4'h8, 8'hFF, 8'h00},
    '{1'b0, 4'h8, 8'h00, 8'h7A},
    '{1'b1, 4'h7, 8'hFF, 8'h00}
  };

  always #25 mclk = ~mclk;

  pif_top i_pif_top (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pir_cond1(c1), .pir_cond2(c2), .pir_cond3(c3), .pir_cond4(c4),
    .core_cond(cc), .core_irq_req(core_irq_req),
    .timer0_and_pin_options(opt), .evt_irq(evt_irq)
  );

  pif_periph_model i_pif_periph_model (
    .fire(fire), .sel(sel), .bits(bits), .ser_lvl(ser_lvl),
    .pir_cond1(c1), .pir_cond2(c2), .pir_cond3(c3), .pir_cond4(c4),
    .core_cond(cc)
  );

  task automatic wr_reg(input pif_addr_t a, input pif_byte_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand one cycle only, so sample mid-cycle after the take
  task automatic rd_chk(input pif_addr_t a, input pif_byte_t e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    `CHK(reg_rdata, e)
  endtask

  task automatic pulse(input logic [2:0] s, input pif_byte_t b);
    @(posedge mclk);
    fire <= 1'b1;
    sel <= s;
    bits <= b;
    @(posedge mclk);
    fire <= 1'b0;
  endtask

  task automatic settle();
    @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd_chk(i[3:0], 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      pulse(i[2:0], 8'hFF);
    end
    settle();
    `CHK(evt_irq, 1'b0)
    for (int i = 0; i < 16; i++) begin
      if (rows[i].wr)
        wr_reg(rows[i].a, rows[i].d);
      else
        rd_chk(rows[i].a, rows[i].e);
    end
    rd_chk(4'h7, 8'hFF);
    `CHK(opt, 8'h5A)
    @(posedge mclk);
    ser_lvl <= 2'h3;
    rd_chk(4'h2, 8'h30);
    wr_reg(4'h2, 8'h00);
    rd_chk(4'h2, 8'h30);
    @(posedge mclk);
    ser_lvl <= 2'h0;
    rd_chk(4'h2, 8'h00);
    pulse(3'h4, 8'h07);
    rd_chk(4'h0, 8'h07);
    wr_reg(4'h0, 8'h00);
    // Stale flags cleared before the global enables go on
    wr_reg(4'h3, 8'h00);
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h5, 8'h00);
    wr_reg(4'h6, 8'h01);
    wr_reg(4'h0, 8'hC0);
    settle();
    `CHK(core_irq_req, 1'b0)
    pulse(3'h0, 8'h01);
    settle();
    `CHK(core_irq_req, 1'b1)
    wr_reg(4'h2, 8'h00);
    settle();
    `CHK(core_irq_req, 1'b0)
    pulse(3'h1, 8'h01);
    settle();
    `CHK(core_irq_req, 1'b1)
    wr_reg(4'h0, 8'h80);
    settle();
    `CHK(core_irq_req, 1'b0)
    wr_reg(4'h0, 8'h88);
    pulse(3'h4, 8'h01);
    settle();
    `CHK(core_irq_req, 1'b1)
    wr_reg(4'h0, 8'h40);
    settle();
    `CHK(core_irq_req, 1'b0)
    wr_reg(4'hB, 8'h01);
    settle();
    `CHK(evt_irq, 1'b1)
    wr_reg(4'hA, 8'h1F);
    settle();
    `CHK(evt_irq, 1'b0)
    // Second reset in mid-run with flags and enables set
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h7, 8'h00);
    `CHK(opt, 8'h00)
    give_verdict();
  end
endmodule
